// [test/rsqm_regs_tb.sv]
// Purpose: Self-checking bench for the signal quality and modem configuration register bank
// Assumes: Zero wait state APB slave, pready one cycle after the setup edge
// Notes:   Busy timing in microsecond units is checked with margins around the 20-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "rsqm_consts.svh"
module rsqm_regs_tb;
    typedef struct {
        logic [31:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
    } rsqm_row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd_v;
    logic [3:0]  pstrb;
    logic        acq_meas_valid, data_meas_valid, bitsync_meas_valid, receive_path_enable;
    logic [15:0] acq_meas_value, data_meas_value, bitsync_meas_value, hdr_length, data_thresh;
    logic        hdr_valid, hdr_crc_ok, rx_bit_tick, quality_met, data_dwell, rd_e;
    logic        usec_units, cqpsk_acquire, qchip_adj_allowed, channel_busy;
    logic [7:0]  dwell_symbols;
    int          n_fail, n_checks;
    // Read-only rows expect the latched measurements, not the write data
    rsqm_row_s   rows [8] = '{'{`RSQM_ADDR_THR_HI, 32'hA5, 32'hA5}, '{`RSQM_ADDR_THR_LO, 32'h5A, 32'h5A},
        '{`RSQM_ADDR_CFG, 32'h7F, 32'h7F}, '{`RSQM_ADDR_ACQ_HI, 32'hFF, 32'h12},
        '{`RSQM_ADDR_ACQ_LO, 32'hFF, 32'h34}, '{`RSQM_ADDR_DAT_HI, 32'h00, 32'hBE},
        '{`RSQM_ADDR_DAT_LO, 32'h00, 32'hEF}, '{`RSQM_ADDR_BSQ, 32'hFF, 32'hC3}};
    logic [31:0] bad [3] = '{32'h0000_00A0, 32'h0000_0081, 32'h0000_0180};

    rsqm_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .acq_meas_valid(acq_meas_valid), .acq_meas_value(acq_meas_value), .data_meas_valid(data_meas_valid),
        .data_meas_value(data_meas_value), .bitsync_meas_valid(bitsync_meas_valid),
        .bitsync_meas_value(bitsync_meas_value), .receive_path_enable(receive_path_enable),
        .hdr_valid(hdr_valid), .hdr_crc_ok(hdr_crc_ok), .hdr_length(hdr_length), .rx_bit_tick(rx_bit_tick),
        .quality_met(quality_met), .data_dwell(data_dwell), .data_thresh(data_thresh),
        .usec_units(usec_units), .cqpsk_acquire(cqpsk_acquire), .qchip_adj_allowed(qchip_adj_allowed),
        .dwell_symbols(dwell_symbols), .channel_busy(channel_busy));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; syncs to an edge first so two transfers never collide in one time step
    // Software keeps the reserved configuration bit at zero in every write
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // No wait count is assumed; only the watchdog ends a hung access
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd_v = prdata;
        rd_e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd_v, exp);
    endtask

    task automatic hdr(input logic [15:0] len, input logic ok);
        @(posedge pclk);
        hdr_valid  <= 1'h1;
        hdr_length <= len;
        hdr_crc_ok <= ok;
        @(posedge pclk);
        hdr_valid <= 1'h0;
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Free-running 20 MHz clock
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    // Watchdog well beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, acq_meas_valid, data_meas_valid, bitsync_meas_valid} = '0;
        {hdr_valid, hdr_crc_ok, rx_bit_tick, quality_met, data_dwell} = '0;
        {paddr, pwdata, acq_meas_value, data_meas_value, bitsync_meas_value, hdr_length} = '0;
        pstrb = 4'hF;
        receive_path_enable = 1'h1;
        n_fail = 0;
        n_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk({31'h0, qchip_adj_allowed}, 32'h1);
        chk({24'h0, dwell_symbols}, 32'h80);
        chk({31'h0, channel_busy}, 32'h0);
        rdchk(`RSQM_ADDR_CFG, 32'h0);
        rdchk(`RSQM_ADDR_THR_HI, 32'h0);
        // Strobe measurements once, then move the values without a strobe
        acq_meas_valid <= 1'h1;
        data_meas_valid <= 1'h1;
        bitsync_meas_valid <= 1'h1;
        acq_meas_value <= 16'h1234;
        data_meas_value <= 16'hBEEF;
        bitsync_meas_value <= 16'hC381;
        @(posedge pclk);
        {acq_meas_valid, data_meas_valid, bitsync_meas_valid} <= 3'h0;
        {acq_meas_value, data_meas_value, bitsync_meas_value} <= {3{16'hFFFF}};
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].wd);
            rdchk(rows[i].a, rows[i].exp);
        end
        // Configuration outputs follow the byte and the qualifying levels
        quality_met <= 1'h1;
        apb(1'h1, `RSQM_ADDR_CFG, 32'h78);
        repeat (2) @(posedge pclk);
        chk({31'h0, usec_units}, 32'h1);
        chk({31'h0, cqpsk_acquire}, 32'h1);
        chk({31'h0, qchip_adj_allowed}, 32'h0);
        chk({24'h0, dwell_symbols}, 32'h40);
        chk({16'h0, data_thresh}, 32'hA55A);
        quality_met <= 1'h0;
        data_dwell <= 1'h1;
        repeat (2) @(posedge pclk);
        chk({31'h0, cqpsk_acquire}, 32'h0);
        chk({31'h0, qchip_adj_allowed}, 32'h1);
        // Refused accesses: unmapped places and a write with no strobe
        foreach (bad[i]) begin
            apb(1'h0, bad[i], 32'h0);
            chk(rd_v, 32'h0);
            chk({31'h0, rd_e}, 32'h1);
        end
        pstrb <= 4'h0;
        apb(1'h1, `RSQM_ADDR_THR_HI, 32'h11);
        pstrb <= 4'hF;
        rdchk(`RSQM_ADDR_THR_HI, 32'hA5);
        // Busy in bit units: failed CRC ignored, then count survives path disable and cfg clear
        apb(1'h1, `RSQM_ADDR_CFG, 32'h04);
        hdr(16'h0005, 1'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, channel_busy}, 32'h0);
        hdr(16'h0003, 1'h1);
        @(posedge pclk);
        chk({31'h0, channel_busy}, 32'h1);
        receive_path_enable <= 1'h0;
        apb(1'h1, `RSQM_ADDR_CFG, 32'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            rx_bit_tick <= 1'h1;
            @(posedge pclk);
            rx_bit_tick <= 1'h0;
            @(posedge pclk);
            chk({31'h0, channel_busy}, {31'h0, i < 2});
        end
        receive_path_enable <= 1'h1;
        // Reset pin clears a running count
        apb(1'h1, `RSQM_ADDR_CFG, 32'h04);
        hdr(16'h0009, 1'h1);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk({31'h0, channel_busy}, 32'h0);
        presetn <= 1'h1;
        rdchk(`RSQM_ADDR_CFG, 32'h0);
        // Microsecond units: bit ticks held high must not shorten a 2 us count
        apb(1'h1, `RSQM_ADDR_CFG, 32'h44);
        rx_bit_tick <= 1'h1;
        hdr(16'h0002, 1'h1);
        repeat (18) @(posedge pclk);
        chk({31'h0, channel_busy}, 32'h1);
        repeat (27) @(posedge pclk);
        chk({31'h0, channel_busy}, 32'h0);
        rx_bit_tick <= 1'h0;
        end_of_test();
    end
endmodule
`default_nettype wire

// [verilog/rsqm_busy_cnt.sv]
// Purpose: Length-field channel busy counter
// Assumes: Reset pin is the only clear; bit and header strobes are one-cycle pulses
// Notes:   Prescaler makes a 1 us tick when microsecond units are chosen
`timescale 1ns/1ps
`default_nettype none
`include "rsqm_consts.svh"
module rsqm_busy_cnt (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        usec_units,
    input  wire logic        hdr_valid,
    input  wire logic        hdr_crc_ok,
    input  wire logic [15:0] hdr_length,
    input  wire logic        rx_bit_tick,
    output logic             busy
);
    typedef struct packed {
        logic [15:0]            cnt;
        logic [`RSQM_PRE_W-1:0] pre;
        logic                   busy;
    } rsqm_cnt_s;

    rsqm_cnt_s cur_ff;
    rsqm_cnt_s nxt_cur;
    logic      tick;

    // Unit tick: microseconds from the prescaler or one per received bit
    assign tick = usec_units ? (cur_ff.pre == `RSQM_PRE_W'(`RSQM_USEC_CYC - 1)) : rx_bit_tick;

    always_comb begin
        nxt_cur = cur_ff;
        if (cur_ff.pre == `RSQM_PRE_W'(`RSQM_USEC_CYC - 1)) begin
            nxt_cur.pre = '0;
        end else begin
            nxt_cur.pre = cur_ff.pre + `RSQM_PRE_W'(1);
        end
        // Failed CRC headers never load; receive disable has no input here on purpose
        if (enable && hdr_valid && hdr_crc_ok) begin
            nxt_cur.cnt = hdr_length;
            nxt_cur.pre = '0;
        end else if (tick && cur_ff.cnt != 16'h0000) begin
            nxt_cur.cnt = cur_ff.cnt - 16'h0001;
        end
        nxt_cur.busy = (nxt_cur.cnt != 16'h0000);
    end

    // Only the reset pin clears the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign busy = cur_ff.busy;

    AST_CRC_FAIL_NO_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (hdr_valid && !hdr_crc_ok && cur_ff.cnt == 16'h0000 && !rx_bit_tick) |=> !cur_ff.busy)
        else $error("busy counter loaded from a failed header");
    AST_LOAD_SHOWS_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && hdr_valid && hdr_crc_ok && hdr_length != 16'h0000) |=> cur_ff.busy && cur_ff.cnt == $past(hdr_length))
        else $error("busy counter did not load the header length");
endmodule
`default_nettype wire

// [verilog/rsqm_consts.svh]
// Purpose: Constants for the receive signal quality and modem configuration register bank
// Assumes: APB byte addresses, 32-bit data, registers in the low byte of each word
// Notes:   Timing counts are derived from the 20 MHz pclk
// Operation
// - Acquisition phase variance is a 16-bit read-only value in a high and a low byte, taken per antenna dwell for the best antenna.
// - The data-dwell phase variance threshold is a 16-bit writable value in a high and a low byte.
// - The data-dwell phase variance measurement is a 16-bit read-only value refreshed each integration.
// - An 8-bit read-only bit sync quality byte is derived from the 16-bit bit sync readback.
// - Configuration bit 6 makes the length counters tick at the BPSK rate, otherwise they count received bits.
// - Configuration bit 5 selects continuous QPSK acquisition, allowed only once quality thresholds are met.
// - Configuration bit 4 permits quarter-chip adjustments only during data dwells.
// - Configuration bit 3 selects 64-symbol data-dwell integration instead of 128.
// - Configuration bit 2 enables a counter that shows the channel busy for the header length time.
// - The busy counter is loaded only when the header CRC passed.
// - The busy counter is cleared only by the reset pin, not by receive disable or modem reset.
// - The 16-bit bit sync quality readback is measured every 128 symbols and used for drop-lock.
`ifndef RSQM_CONSTS_SVH
`define RSQM_CONSTS_SVH

`define RSQM_ADDR_ACQ_HI     8'h80
`define RSQM_ADDR_ACQ_LO     8'h84
`define RSQM_ADDR_THR_HI     8'h88
`define RSQM_ADDR_THR_LO     8'h8C
`define RSQM_ADDR_DAT_HI     8'h90
`define RSQM_ADDR_DAT_LO     8'h94
`define RSQM_ADDR_BSQ        8'h98
`define RSQM_ADDR_CFG        8'h9C

`define RSQM_CFG_RESV_BIT    7
`define RSQM_CFG_USEC_BIT    6
`define RSQM_CFG_CQPSK_BIT   5
`define RSQM_CFG_QCHIP_BIT   4
`define RSQM_CFG_INT64_BIT   3
`define RSQM_CFG_BUSY_BIT    2
`define RSQM_CFG_WMASK       8'h7F
`define RSQM_CFG_RESET       8'h00
`define RSQM_THR_RESET       16'h0000

`define RSQM_INT_LONG        8'h80
`define RSQM_INT_SHORT       8'h40
`define RSQM_BSQ_MSB         15
`define RSQM_BSQ_LSB         8

// One microsecond at the BPSK rate of one bit per microsecond, in pclk cycles
`define RSQM_USEC_NS         1000
`define RSQM_CLK_NS          50
`define RSQM_USEC_CYC        (`RSQM_USEC_NS / `RSQM_CLK_NS)
`define RSQM_PRE_W           5

`endif

// [verilog/rsqm_pkg.sv]
// Purpose: Types used by the register bank, not by its busy counter
// Assumes: Constants come from rsqm_consts.svh
// Notes:   Types only
package rsqm_pkg;
    typedef logic [7:0]  rsqm_byte_t;
    typedef logic [15:0] rsqm_word_t;
    typedef enum logic [1:0] {
        RSQM_IDLE,
        RSQM_SETUP,
        RSQM_ACCESS
    } rsqm_apb_e;
endpackage

// [verilog/rsqm_regs.sv]
// Purpose: APB register bank for signal quality readbacks and the modem configuration byte
// Assumes: Measurement strobes are one-cycle pulses in the pclk domain
// Notes:   Zero wait states; unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
`default_nettype none
`include "rsqm_consts.svh"
module rsqm_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        acq_meas_valid,
    input  wire logic [15:0] acq_meas_value,
    input  wire logic        data_meas_valid,
    input  wire logic [15:0] data_meas_value,
    input  wire logic        bitsync_meas_valid,
    input  wire logic [15:0] bitsync_meas_value,
    input  wire logic        receive_path_enable,
    input  wire logic        hdr_valid,
    input  wire logic        hdr_crc_ok,
    input  wire logic [15:0] hdr_length,
    input  wire logic        rx_bit_tick,
    input  wire logic        quality_met,
    input  wire logic        data_dwell,
    output logic [15:0]      data_thresh,
    output logic             usec_units,
    output logic             cqpsk_acquire,
    output logic             qchip_adj_allowed,
    output logic [7:0]       dwell_symbols,
    output logic             channel_busy
);
    typedef struct packed {
        rsqm_pkg::rsqm_word_t acq;
        rsqm_pkg::rsqm_word_t dat;
        rsqm_pkg::rsqm_word_t bsq16;
        rsqm_pkg::rsqm_word_t thr;
        rsqm_pkg::rsqm_byte_t cfg;
        logic [31:0]          rdata;
        logic                 ready;
        logic                 err;
        logic                 cqpsk;
        logic                 qchip;
        logic [7:0]           dwell;
    } rsqm_regs_s;

    rsqm_regs_s cur_ff;
    rsqm_regs_s nxt_cur;
    logic       busy_w;

    // Address decode shared by read and write paths
    function automatic logic rsqm_mapped(input logic [31:0] a);
        unique case (a[7:0])
            `RSQM_ADDR_ACQ_HI, `RSQM_ADDR_ACQ_LO, `RSQM_ADDR_THR_HI, `RSQM_ADDR_THR_LO,
            `RSQM_ADDR_DAT_HI, `RSQM_ADDR_DAT_LO, `RSQM_ADDR_BSQ, `RSQM_ADDR_CFG: rsqm_mapped = (a[31:8] == 24'h000000);
            default: rsqm_mapped = 1'b0;
        endcase
    endfunction

    // Busy counter sits outside the receive reset so RX disable does not stop it
    rsqm_busy_cnt u_busy (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (cur_ff.cfg[`RSQM_CFG_BUSY_BIT]),
        .usec_units  (cur_ff.cfg[`RSQM_CFG_USEC_BIT]),
        .hdr_valid   (hdr_valid),
        .hdr_crc_ok  (hdr_crc_ok),
        .hdr_length  (hdr_length),
        .rx_bit_tick (rx_bit_tick),
        .busy        (busy_w)
    );

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.ready = 1'b0;
        nxt_cur.err = 1'b0;
        // Whole 16-bit words latched at once so high and low bytes always match
        if (acq_meas_valid) begin
            nxt_cur.acq = acq_meas_value;
        end
        if (data_meas_valid) begin
            nxt_cur.dat = data_meas_value;
        end
        if (bitsync_meas_valid) begin
            nxt_cur.bsq16 = bitsync_meas_value;
        end
        // APB setup cycle: answer in the following access cycle
        if (psel && !penable) begin
            nxt_cur.ready = 1'b1;
            nxt_cur.err = !rsqm_mapped(paddr);
            nxt_cur.rdata = 32'h00000000;
            if (!pwrite) begin
                unique case (paddr[7:0])
                    `RSQM_ADDR_ACQ_HI: nxt_cur.rdata[7:0] = cur_ff.acq[15:8];
                    `RSQM_ADDR_ACQ_LO: nxt_cur.rdata[7:0] = cur_ff.acq[7:0];
                    `RSQM_ADDR_THR_HI: nxt_cur.rdata[7:0] = cur_ff.thr[15:8];
                    `RSQM_ADDR_THR_LO: nxt_cur.rdata[7:0] = cur_ff.thr[7:0];
                    `RSQM_ADDR_DAT_HI: nxt_cur.rdata[7:0] = cur_ff.dat[15:8];
                    `RSQM_ADDR_DAT_LO: nxt_cur.rdata[7:0] = cur_ff.dat[7:0];
                    `RSQM_ADDR_BSQ:    nxt_cur.rdata[7:0] = cur_ff.bsq16[`RSQM_BSQ_MSB:`RSQM_BSQ_LSB];
                    `RSQM_ADDR_CFG:    nxt_cur.rdata[7:0] = cur_ff.cfg;
                    default:           nxt_cur.rdata = 32'h00000000;
                endcase
                if (!rsqm_mapped(paddr)) begin
                    nxt_cur.rdata = 32'h00000000;
                end
            end
        end
        // Writes commit at the edge where the master samples pready, so a write and its completion coincide
        if (psel && penable && cur_ff.ready && pwrite && pstrb[0] && rsqm_mapped(paddr)) begin
            unique case (paddr[7:0])
                `RSQM_ADDR_THR_HI: nxt_cur.thr[15:8] = pwdata[7:0];
                `RSQM_ADDR_THR_LO: nxt_cur.thr[7:0] = pwdata[7:0];
                // Reserved bit 7 is held at zero whatever software writes
                `RSQM_ADDR_CFG:    nxt_cur.cfg = pwdata[7:0] & `RSQM_CFG_WMASK;
                default:           nxt_cur.cfg = cur_ff.cfg;
            endcase
        end
        // Mode outputs for the acquisition and tracking engines
        nxt_cur.cqpsk = nxt_cur.cfg[`RSQM_CFG_CQPSK_BIT] && quality_met;
        nxt_cur.qchip = !nxt_cur.cfg[`RSQM_CFG_QCHIP_BIT] || data_dwell;
        nxt_cur.dwell = nxt_cur.cfg[`RSQM_CFG_INT64_BIT] ? `RSQM_INT_SHORT : `RSQM_INT_LONG;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
            cur_ff.cfg <= `RSQM_CFG_RESET;
            cur_ff.thr <= `RSQM_THR_RESET;
            cur_ff.qchip <= 1'b1;
            cur_ff.dwell <= `RSQM_INT_LONG;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Registered outputs; busy comes straight from the counter flop
    assign pready = cur_ff.ready;
    assign prdata = cur_ff.rdata;
    assign pslverr = cur_ff.err;
    assign data_thresh = cur_ff.thr;
    assign usec_units = cur_ff.cfg[`RSQM_CFG_USEC_BIT];
    assign cqpsk_acquire = cur_ff.cqpsk;
    assign qchip_adj_allowed = cur_ff.qchip;
    assign dwell_symbols = cur_ff.dwell;
    assign channel_busy = busy_w;

    AST_CFG_RESV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        !cur_ff.cfg[`RSQM_CFG_RESV_BIT])
        else $error("reserved config bit set");
    AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no ready after setup");
    AST_ACQ_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        acq_meas_valid |=> cur_ff.acq == $past(acq_meas_value))
        else $error("acq measurement not captured");
    AST_DATA_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        data_meas_valid |=> cur_ff.dat == $past(data_meas_value))
        else $error("data measurement not captured");
    AST_BSQ_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        bitsync_meas_valid |=> cur_ff.bsq16 == $past(bitsync_meas_value))
        else $error("bit sync readback not captured");
    AST_DWELL_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        dwell_symbols == (cur_ff.cfg[`RSQM_CFG_INT64_BIT] ? `RSQM_INT_SHORT : `RSQM_INT_LONG))
        else $error("dwell length mismatch");
    AST_CQPSK_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        cqpsk_acquire |-> cur_ff.cfg[`RSQM_CFG_CQPSK_BIT] && $past(quality_met))
        else $error("continuous QPSK without quality");
    AST_QCHIP: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_ff.cfg[`RSQM_CFG_QCHIP_BIT] && $past(cur_ff.cfg[`RSQM_CFG_QCHIP_BIT]) && !$past(data_dwell)) |-> !qchip_adj_allowed)
        else $error("quarter chip allowed outside data dwell");
endmodule
`default_nettype wire
